// *** rtl/dcmc_pkg.sv ***
// Function
// - both flags clear: read hits from cache, read misses allocate and replace, invalidations honoured
// - normal mode fill enters Exclusive or Shared as the line policy pin selects
// - normal mode: only Shared write hits and write misses go to the bus
// - external write to Shared line may become Exclusive when the policy pin says so
// - write hits update the cached line in normal and consistent disabled mode
// - cache-off alone: no allocation, contents kept, memory consistent, read hits served
// - with cache-off set a read miss reads memory without allocating or evicting
// - consistent disabled mode: only Shared write hits and write misses update memory
// - both flags set: read and write hits stay in cache, no memory access
// - both flags set: write hit on Exclusive line makes it Modified
// - both flags set: write hit on Shared line leaves it Shared
// - both flags set: write miss goes to memory without allocating
// - both flags set: inquire and invalidate cycles change no line
// - after reset both flags are one
package dcmc_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int INDEX_W = 4;
    localparam int WORD_LSB = 2;
    localparam logic CACHE_OFF_RST = 1'b1;
    localparam logic NO_WT_RST = 1'b1;

    typedef enum logic [1:0] {
        DCMC_INV,
        DCMC_SHR,
        DCMC_EXC,
        DCMC_MOD
    } dcmc_line_e;

    typedef enum logic [2:0] {
        DCMC_IDLE,
        DCMC_EVICT,
        DCMC_FILL,
        DCMC_WRITE,
        DCMC_RESP
    } dcmc_fsm_e;
endpackage

// *** rtl/dcmc_policy.sv ***
`timescale 1ns/1ps
module dcmc_policy (
    // mode
    input wire logic i_cache_off,
    input wire logic i_no_wt,
    // access
    input wire logic i_write,
    input wire logic i_hit,
    input wire dcmc_pkg::dcmc_line_e i_state,
    // decision
    output logic o_alloc,
    output logic o_external,
    output logic o_update,
    output dcmc_pkg::dcmc_line_e o_wr_state,
    output logic o_snoop_honour
);
    wire shared_hit = i_hit && (i_state == dcmc_pkg::DCMC_SHR);
    wire non_consistent = i_cache_off && i_no_wt;

    // allocation only with cache on; disabled modes never evict
    assign o_alloc = !i_cache_off && !i_write && !i_hit;
    // read misses always use the bus; writes per mode
    assign o_external = !i_write ? !i_hit :
                        !i_hit ? 1'b1 :
                        non_consistent ? 1'b0 :
                        shared_hit;
    assign o_update = i_write && i_hit;
    // shared lines keep their state until the bus answers
    assign o_wr_state = (i_state == dcmc_pkg::DCMC_SHR) ? dcmc_pkg::DCMC_SHR :
                        dcmc_pkg::DCMC_MOD;
    assign o_snoop_honour = !non_consistent;
endmodule // dcmc_policy

// *** rtl/dcmc_cache.sv ***
`timescale 1ns/1ps
module dcmc_cache #(
    parameter int ADDR_W = dcmc_pkg::ADDR_W,
    parameter int DATA_W = dcmc_pkg::DATA_W,
    parameter int INDEX_W = dcmc_pkg::INDEX_W
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // control register zero load
    input wire logic i_cr_load,
    input wire logic i_cache_off_flag,
    input wire logic i_no_write_through_flag,
    output logic o_cache_off_flag,
    output logic o_no_write_through_flag,
    output logic o_general_protection_fault,
    // core access
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [ADDR_W-1:0] i_req_addr,
    input wire logic [DATA_W-1:0] i_req_wdata,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [DATA_W-1:0] o_rsp_rdata,
    // system bus
    output logic o_bus_valid,
    output logic o_bus_write,
    output logic [ADDR_W-1:0] o_bus_addr,
    output logic [DATA_W-1:0] o_bus_wdata,
    input wire logic i_bus_done,
    input wire logic [DATA_W-1:0] i_bus_rdata,
    input wire logic i_line_policy_pin,
    // snoop
    input wire logic i_snoop_valid,
    input wire logic i_snoop_inval,
    input wire logic [ADDR_W-1:0] i_snoop_addr,
    output logic o_snoop_hit,
    output logic o_snoop_hitm
);
    localparam int LINES = 1 << INDEX_W;
    localparam int TAG_LSB = INDEX_W + dcmc_pkg::WORD_LSB;
    localparam int TAG_W = ADDR_W - TAG_LSB;

    dcmc_pkg::dcmc_line_e line_state_q [LINES];
    logic [TAG_W-1:0] line_tag_q [LINES];
    logic [DATA_W-1:0] line_data_q [LINES];

    logic cache_off_q;
    logic no_wt_q;
    logic fault_q;
    dcmc_pkg::dcmc_fsm_e fsm_q;
    logic alloc_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] rdata_q;
    logic bus_write_q;
    logic [ADDR_W-1:0] bus_addr_q;
    logic [DATA_W-1:0] bus_wdata_q;
    logic snoop_hit_q;
    logic snoop_hitm_q;

    // request lookup
    wire [INDEX_W-1:0] req_idx = i_req_addr[TAG_LSB-1:dcmc_pkg::WORD_LSB];
    wire [TAG_W-1:0] req_tag = i_req_addr[ADDR_W-1:TAG_LSB];
    wire dcmc_pkg::dcmc_line_e req_state = line_state_q[req_idx];
    wire req_hit = (req_state != dcmc_pkg::DCMC_INV) && (line_tag_q[req_idx] == req_tag);
    wire accept = (fsm_q == dcmc_pkg::DCMC_IDLE) && i_req_valid;

    // pending lookup
    wire [INDEX_W-1:0] pend_idx = addr_q[TAG_LSB-1:dcmc_pkg::WORD_LSB];
    wire [TAG_W-1:0] pend_tag = addr_q[ADDR_W-1:TAG_LSB];
    wire pend_shared = (line_state_q[pend_idx] == dcmc_pkg::DCMC_SHR)
                       && (line_tag_q[pend_idx] == pend_tag);

    // snoop lookup
    wire [INDEX_W-1:0] snp_idx = i_snoop_addr[TAG_LSB-1:dcmc_pkg::WORD_LSB];
    wire snp_match = (line_state_q[snp_idx] != dcmc_pkg::DCMC_INV)
                     && (line_tag_q[snp_idx] == i_snoop_addr[ADDR_W-1:TAG_LSB]);

    logic pol_alloc;
    logic pol_external;
    logic pol_update;
    dcmc_pkg::dcmc_line_e pol_wr_state;
    logic pol_snoop_honour;

    dcmc_policy u_policy (
        .i_cache_off(cache_off_q),
        .i_no_wt(no_wt_q),
        .i_write(i_req_write),
        .i_hit(req_hit),
        .i_state(req_state),
        .o_alloc(pol_alloc),
        .o_external(pol_external),
        .o_update(pol_update),
        .o_wr_state(pol_wr_state),
        .o_snoop_honour(pol_snoop_honour)
    );

    // victim needs writing back before its slot is reused
    wire victim_dirty = pol_alloc && (req_state == dcmc_pkg::DCMC_MOD);
    wire [ADDR_W-1:0] victim_addr = {line_tag_q[req_idx], req_idx,
                                     {dcmc_pkg::WORD_LSB{1'b0}}};

    // control register load
    wire cr_illegal = !i_cache_off_flag && i_no_write_through_flag;
    wire cr_take = i_cr_load && !cr_illegal;

    // single line write port from the sequencer
    wire fill_done = (fsm_q == dcmc_pkg::DCMC_FILL) && i_bus_done;
    wire write_done = (fsm_q == dcmc_pkg::DCMC_WRITE) && i_bus_done;
    wire fsm_we_hit = accept && pol_update;
    wire fsm_we_fill = fill_done && alloc_q;
    wire fsm_we_up = write_done && pend_shared && i_line_policy_pin;
    wire fsm_we = fsm_we_hit || fsm_we_fill || fsm_we_up;
    wire [INDEX_W-1:0] fsm_idx = accept ? req_idx : pend_idx;
    wire fill_excl = i_line_policy_pin;
    wire dcmc_pkg::dcmc_line_e fsm_state =
        fsm_we_hit ? pol_wr_state :
        fsm_we_fill ? (fill_excl ? dcmc_pkg::DCMC_EXC : dcmc_pkg::DCMC_SHR) :
        dcmc_pkg::DCMC_EXC;
    wire fsm_data_we = fsm_we_hit || fsm_we_fill;
    wire [DATA_W-1:0] fsm_data = fsm_we_hit ? i_req_wdata : i_bus_rdata;
    wire snp_inv_we = i_snoop_valid && i_snoop_inval && snp_match && pol_snoop_honour;

    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            wire fsm_sel = fsm_we && (fsm_idx == INDEX_W'(g));
            wire snp_sel = snp_inv_we && (snp_idx == INDEX_W'(g));
            // the sequencer write wins over a same-cycle invalidate of that slot
            always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    line_state_q[g] <= dcmc_pkg::DCMC_INV;
                end else if (fsm_sel) begin
                    line_state_q[g] <= fsm_state;
                end else if (snp_sel) begin
                    line_state_q[g] <= dcmc_pkg::DCMC_INV;
                end
            end
            always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    line_tag_q[g] <= '0;
                    line_data_q[g] <= '0;
                end else if (fsm_sel && fsm_data_we) begin
                    line_data_q[g] <= fsm_data;
                    if (fsm_we_fill) begin
                        line_tag_q[g] <= pend_tag;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cache_off_q <= dcmc_pkg::CACHE_OFF_RST;
            no_wt_q <= dcmc_pkg::NO_WT_RST;
            fault_q <= 1'b0;
        end else begin
            fault_q <= i_cr_load && cr_illegal;
            if (cr_take) begin
                cache_off_q <= i_cache_off_flag;
                no_wt_q <= i_no_write_through_flag;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            snoop_hit_q <= 1'b0;
            snoop_hitm_q <= 1'b0;
        end else begin
            snoop_hit_q <= i_snoop_valid && snp_match && pol_snoop_honour;
            snoop_hitm_q <= i_snoop_valid && snp_match && pol_snoop_honour
                            && (line_state_q[snp_idx] == dcmc_pkg::DCMC_MOD);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fsm_q <= dcmc_pkg::DCMC_IDLE;
            alloc_q <= 1'b0;
            addr_q <= '0;
            rdata_q <= '0;
            bus_write_q <= 1'b0;
            bus_addr_q <= '0;
            bus_wdata_q <= '0;
        end else begin
            case (fsm_q)
                dcmc_pkg::DCMC_IDLE: begin
                    if (i_req_valid) begin
                        alloc_q <= pol_alloc;
                        addr_q <= i_req_addr;
                        // write responses echo the write data from the same register
                        rdata_q <= i_req_write ? i_req_wdata : line_data_q[req_idx];
                        bus_write_q <= i_req_write || victim_dirty;
                        bus_addr_q <= victim_dirty ? victim_addr : i_req_addr;
                        bus_wdata_q <= victim_dirty ? line_data_q[req_idx] : i_req_wdata;
                        if (!pol_external) begin
                            fsm_q <= dcmc_pkg::DCMC_RESP;
                        end else if (i_req_write) begin
                            fsm_q <= dcmc_pkg::DCMC_WRITE;
                        end else if (victim_dirty) begin
                            fsm_q <= dcmc_pkg::DCMC_EVICT;
                        end else begin
                            fsm_q <= dcmc_pkg::DCMC_FILL;
                        end
                    end
                end
                dcmc_pkg::DCMC_EVICT: begin
                    if (i_bus_done) begin
                        bus_write_q <= 1'b0;
                        bus_addr_q <= addr_q;
                        fsm_q <= dcmc_pkg::DCMC_FILL;
                    end
                end
                dcmc_pkg::DCMC_FILL: begin
                    if (i_bus_done) begin
                        rdata_q <= i_bus_rdata;
                        fsm_q <= dcmc_pkg::DCMC_RESP;
                    end
                end
                dcmc_pkg::DCMC_WRITE: begin
                    if (i_bus_done) begin
                        fsm_q <= dcmc_pkg::DCMC_RESP;
                    end
                end
                dcmc_pkg::DCMC_RESP: begin
                    fsm_q <= dcmc_pkg::DCMC_IDLE;
                end
                default: begin
                    fsm_q <= dcmc_pkg::DCMC_IDLE;
                end
            endcase
        end
    end

    assign o_cache_off_flag = cache_off_q;
    assign o_no_write_through_flag = no_wt_q;
    assign o_general_protection_fault = fault_q;
    assign o_req_ready = (fsm_q == dcmc_pkg::DCMC_IDLE);
    assign o_rsp_valid = (fsm_q == dcmc_pkg::DCMC_RESP);
    // held from the lookup, the fill or the write request until the next request is taken
    assign o_rsp_rdata = rdata_q;
    assign o_bus_valid = (fsm_q == dcmc_pkg::DCMC_EVICT) || (fsm_q == dcmc_pkg::DCMC_FILL)
                         || (fsm_q == dcmc_pkg::DCMC_WRITE);
    assign o_bus_write = bus_write_q;
    assign o_bus_addr = bus_addr_q;
    assign o_bus_wdata = bus_wdata_q;
    assign o_snoop_hit = snoop_hit_q;
    assign o_snoop_hitm = snoop_hitm_q;
endmodule // dcmc_cache

// *** verif/dcmc_cache_chk.sv ***
`timescale 1ns/1ps
module dcmc_cache_chk #(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // mode load
    input wire logic i_cr_load,
    input wire logic i_cache_off_flag,
    input wire logic i_no_write_through_flag,
    input wire logic o_cache_off_flag,
    input wire logic o_no_write_through_flag,
    input wire logic o_general_protection_fault,
    // core and bus
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic o_req_ready,
    input wire logic o_bus_valid,
    input wire logic o_bus_write,
    input wire logic [ADDR_W-1:0] o_bus_addr,
    input wire logic i_bus_done,
    // snoop
    input wire logic i_snoop_valid,
    input wire logic o_snoop_hit,
    input wire logic o_snoop_hitm
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    wire bad_load = i_cr_load && !i_cache_off_flag && i_no_write_through_flag;
    wire mode_11 = o_cache_off_flag && o_no_write_through_flag;
    wire taken = i_req_valid && o_req_ready;
    a_fault_on_bad: assert property (bad_load |=> o_general_protection_fault)
        else $error("no fault after illegal load");
    a_bad_keeps_flags: assert property (bad_load |=> $stable(o_cache_off_flag) &&
        $stable(o_no_write_through_flag)) else $error("illegal load changed flags");
    a_good_load: assert property (i_cr_load && !bad_load |=>
        o_cache_off_flag == $past(i_cache_off_flag) &&
        o_no_write_through_flag == $past(i_no_write_through_flag)) else $error("load lost");
    a_reset_mode: assert property ($rose(i_reset_n) |-> mode_11)
        else $error("flags not set after reset");
    a_quiet_snoop: assert property (i_snoop_valid && mode_11 |=>
        !o_snoop_hit && !o_snoop_hitm) else $error("snoop answered in mode 11");
    a_bus_held: assert property (o_bus_valid && !i_bus_done |=> o_bus_valid &&
        $stable(o_bus_addr) && $stable(o_bus_write)) else $error("bus request moved");
    a_off_no_evict: assert property (taken && !i_req_write && o_cache_off_flag |=>
        (!(o_bus_valid && o_bus_write)) [*2]) else $error("eviction with cache off");
    a_nc_write_only: assert property (taken && i_req_write && mode_11 |=>
        !o_bus_valid || o_bus_write) else $error("write miss allocated");
    c_fault: cover property (bad_load ##1 o_general_protection_fault);
    c_fill: cover property (o_bus_valid && i_bus_done && !o_bus_write);
    c_snoop_11: cover property (i_snoop_valid && mode_11);
endmodule // dcmc_cache_chk

bind dcmc_cache dcmc_cache_chk #(.ADDR_W(ADDR_W)) u_chk (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cr_load(i_cr_load),
    .i_cache_off_flag(i_cache_off_flag), .i_no_write_through_flag(i_no_write_through_flag),
    .o_cache_off_flag(o_cache_off_flag), .o_no_write_through_flag(o_no_write_through_flag),
    .o_general_protection_fault(o_general_protection_fault), .i_req_valid(i_req_valid),
    .i_req_write(i_req_write), .o_req_ready(o_req_ready), .o_bus_valid(o_bus_valid),
    .o_bus_write(o_bus_write), .o_bus_addr(o_bus_addr), .i_bus_done(i_bus_done),
    .i_snoop_valid(i_snoop_valid), .o_snoop_hit(o_snoop_hit), .o_snoop_hitm(o_snoop_hitm)
);

// *** verif/dcmc_bus_model.sv ***
`timescale 1ns/1ps
module dcmc_bus_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // transfer and test controls
    input wire logic i_valid,
    input wire logic [31:0] i_addr,
    input wire logic [1:0] i_wait,
    input wire logic i_pin_sel,
    // answer
    output logic o_done,
    output logic [31:0] o_rdata,
    output logic o_pin
);
    logic [1:0] cnt_q;
    logic [31:0] junk_q;
    // outside done the lines churn so a stale sample cannot pass
    assign o_rdata = o_done ? (i_addr ^ 32'h3c3c_0000) : junk_q;
    assign o_pin = o_done ? i_pin_sel : junk_q[0];
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q <= 2'h0;
            o_done <= 1'b0;
            junk_q <= 32'h0;
        end else begin
            junk_q <= junk_q + 32'h9e37_79b9;
            o_done <= i_valid && !o_done && cnt_q == i_wait;
            cnt_q <= (i_valid && !o_done && cnt_q != i_wait) ? cnt_q + 2'h1 : 2'h0;
        end
    end
endmodule // dcmc_bus_model

// *** verif/data_cache_mode_control_test.sv ***
`timescale 1ns/1ps
module data_cache_mode_control_test;
    logic clk = 1'b0, rst_n = 1'b0, ld = 1'b0, off_in = 1'b0, nowt_in = 1'b0, rq_v = 1'b0;
    logic rq_w = 1'b0, sn_v = 1'b0, sn_i = 1'b0, pin_sel = 1'b0, exp_off = 1'b1;
    logic exp_nowt = 1'b1;
    logic off_f, nowt_f, gpf, rdy, rsp_v, b_v, b_w, done, pin, hit, hitm, h, hm;
    logic [1:0] wait_sel = 2'h0;
    logic [31:0] rq_a = 32'h0, rq_d = 32'h0, sn_a = 32'h0, nbus = 32'h0;
    logic [31:0] rsp_d, b_a, b_d, b_rd, lw_data, rd, nb, d, a_s, a_e, a_c, a_d, a_m;
    int mismatches = 0, samples_checked = 0, cycles = 0, seed = 50;
    always #4 clk = ~clk;
    dcmc_cache u_dut (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_cr_load(ld), .i_cache_off_flag(off_in),
        .i_no_write_through_flag(nowt_in), .o_cache_off_flag(off_f),
        .o_no_write_through_flag(nowt_f),
        .o_general_protection_fault(gpf), .i_req_valid(rq_v), .i_req_write(rq_w),
        .i_req_addr(rq_a), .i_req_wdata(rq_d), .o_req_ready(rdy), .o_rsp_valid(rsp_v),
        .o_rsp_rdata(rsp_d), .o_bus_valid(b_v), .o_bus_write(b_w), .o_bus_addr(b_a),
        .o_bus_wdata(b_d), .i_bus_done(done), .i_bus_rdata(b_rd), .i_line_policy_pin(pin),
        .i_snoop_valid(sn_v), .i_snoop_inval(sn_i), .i_snoop_addr(sn_a),
        .o_snoop_hit(hit), .o_snoop_hitm(hitm)
    );
    dcmc_bus_model u_bus (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_valid(b_v), .i_addr(b_a), .i_wait(wait_sel),
        .i_pin_sel(pin_sel), .o_done(done), .o_rdata(b_rd), .o_pin(pin)
    );
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bus completions are counted here so every access knows its external traffic
    always @(posedge clk) begin
        cycles++;
        if (b_v && done) nbus = nbus + 32'h1;
        if (b_v && done && b_w) lw_data = b_d;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end
    function automatic logic [31:0] mk(input logic [3:0] idx);
        logic [31:0] r;
        r = $random(seed);
        return {r[31:6], idx, 2'b00};
    endfunction
    task automatic load(input logic off, input logic nowt);
        logic bad;
        bad = !off && nowt;
        ld <= 1'b1;
        off_in <= off;
        nowt_in <= nowt;
        @(posedge clk);
        ld <= 1'b0;
        @(posedge clk);
        if (!bad) exp_off = off;
        if (!bad) exp_nowt = nowt;
        chk("fault", 32'(bad), 32'(gpf));
        chk("flags", {30'h0, exp_off, exp_nowt}, {30'h0, off_f, nowt_f});
    endtask
    task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        input logic p);
        logic [31:0] n0;
        int t;
        n0 = nbus;
        pin_sel <= p;
        wait_sel <= 2'($random(seed));
        rq_v <= 1'b1;
        rq_w <= wr;
        rq_a <= a;
        rq_d <= wd;
        @(posedge clk);
        rq_v <= 1'b0;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (rsp_v !== 1'b1 && t < 40);
        if (t == 40) chk("response", 32'h1, 32'h0);
        rd = rsp_d;
        nb = nbus - n0;
    endtask
    task automatic snoop(input logic inv, input logic [31:0] a);
        sn_v <= 1'b1;
        sn_i <= inv;
        sn_a <= a;
        @(posedge clk);
        sn_v <= 1'b0;
        @(posedge clk);
        h = hit;
        hm = hitm;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset_flags", 32'h3, {30'h0, off_f, nowt_f});
        load(1'b0, 1'b1);
        load(1'b0, 1'b0);
        $display("test mode load done");
        {a_s, a_e, a_c, a_d, d} = {mk(4'h1), mk(4'h2), mk(4'h3), mk(4'h4), 32'($random(seed))};
        access(1'b0, a_s, d, 1'b0);
        chk("miss_data", a_s ^ 32'h3c3c_0000, rd);
        access(1'b0, a_s, d, 1'b0);
        chk("hit_bus", 32'h0, nb);
        access(1'b1, a_s, d, 1'b1);
        chk("shr_wr", {nb[15:0], 16'h0} | (lw_data ^ d), 32'h0001_0000);
        chk("wr_echo", d, rd);
        access(1'b1, a_s, d + 32'h1, 1'b0);
        chk("exc_wr_bus", 32'h0, nb);
        access(1'b0, a_s, d, 1'b0);
        chk("wr_hit_data", d + 32'h1, rd);
        snoop(1'b1, a_s);
        chk("hitm", 32'h1, 32'(hm));
        access(1'b0, a_s, d, 1'b0);
        chk("inval_refill", 32'h1, nb);
        access(1'b0, a_e, d, 1'b1);
        access(1'b1, a_e, d, 1'b0);
        chk("exc_fill_wr", 32'h0, nb);
        access(1'b1, a_c, d, 1'b0);
        access(1'b0, a_c, d, 1'b0);
        chk("wr_miss_noalloc", 32'h1, nb);
        access(1'b0, a_d, d, 1'b1);
        $display("test normal done");
        load(1'b1, 1'b0);
        a_m = mk(4'h2);
        access(1'b0, a_m, d, 1'b1);
        chk("off_miss", 32'h1, nb);
        access(1'b0, a_e, d, 1'b0);
        chk("off_hit", d, rd);
        access(1'b0, a_m, d, 1'b0);
        chk("off_noalloc", 32'h1, nb);
        access(1'b1, a_c, d + 32'h2, 1'b0);
        chk("off_shr_wr", d + 32'h2, lw_data);
        $display("test consistent done");
        load(1'b1, 1'b1);
        access(1'b1, a_d, d, 1'b0);
        chk("nc_exc_wr", 32'h0, nb);
        access(1'b1, a_c, d + 32'h3, 1'b0);
        access(1'b0, a_c, d, 1'b0);
        chk("nc_shr_rd", d + 32'h3, rd);
        a_m = mk(4'h6);
        access(1'b1, a_m, d, 1'b0);
        access(1'b0, a_m, d, 1'b0);
        chk("nc_wr_miss", 32'h1, nb);
        snoop(1'b1, a_c);
        chk("nc_snoop", 32'h0, {30'h0, h, hm});
        load(1'b1, 1'b0);
        snoop(1'b0, a_d);
        chk("exc_to_mod", 32'h1, 32'(hm));
        snoop(1'b0, a_c);
        chk("shr_stays", 32'h2, {30'h0, h, hm});
        $display("test non consistent done");
        load(1'b0, 1'b0);
        a_m = mk(4'h4);
        access(1'b0, a_m, d, 1'b0);
        chk("evict_count", 32'h2, nb);
        chk("evict_data", d, lw_data);
        chk("evict_fill", a_m ^ 32'h3c3c_0000, rd);
        $display("test eviction done");
        stop_test();
    end
endmodule // data_cache_mode_control_test
